//--- logic/sepc_regs.svh
`ifndef SEPC_REGS_SVH
`define SEPC_REGS_SVH

// Instruction codes
`define SEPC_OP_SET_WL      8'h06
`define SEPC_OP_CLR_WL      8'h04
`define SEPC_OP_RD_SR       8'h05
`define SEPC_OP_WR_SR       8'h01
`define SEPC_OP_RD_MEM      8'h03
`define SEPC_OP_WR_MEM      8'h02

// Status field positions
`define SEPC_SR_PGE         7
`define SEPC_SR_BGH         3
`define SEPC_SR_BGL         2
`define SEPC_SR_WL          1
`define SEPC_SR_BUSY        0

// Array geometry
`define SEPC_ABITS_BIG      11
`define SEPC_ABITS_SMALL    10
`define SEPC_MASK_BIG       11'h7ff
`define SEPC_MASK_SMALL     11'h3ff

// Timing
`define SEPC_CLK_NS         10
`define SEPC_SCK_HALF_NS    80
`define SEPC_SCK_HALF_CYC   (`SEPC_SCK_HALF_NS / `SEPC_CLK_NS)
`define SEPC_PROG_US        5000
`define SEPC_PROG_CYC       (`SEPC_PROG_US * 1000 / `SEPC_CLK_NS)

// Controller register offsets
`define SEPC_CMD_OFS        8'h00
`define SEPC_ADDR_OFS       8'h04
`define SEPC_TXD_OFS        8'h08
`define SEPC_RXD_OFS        8'h0c
`define SEPC_CTRL_OFS       8'h10
`define SEPC_STAT_OFS       8'h14

// Controller fields and reset values
`define SEPC_CMD_HAS_ADDR   8
`define SEPC_CMD_HAS_DATA   9
`define SEPC_CTRL_WP        0
`define SEPC_CTRL_RST       1'b1

`endif

//--- logic/sepc_pkg.sv
package sepc_pkg;

    typedef logic [7:0] sepc_byte_t;

    typedef enum logic [2:0] {
        D_OPC,
        D_ADH,
        D_ADL,
        D_WIN,
        D_SRIN,
        D_RDOUT,
        D_SROUT,
        D_SKIP
    } sepc_dphase_t;

    typedef enum logic [2:0] {
        H_IDLE,
        H_LEAD,
        H_SHIFT,
        H_TRAIL,
        H_GAP
    } sepc_hstate_t;

endpackage : sepc_pkg

//--- logic/sepc_if.sv
`timescale 1ns/100ps
interface sepc_if;
    logic cs_n;
    logic sck;
    logic si;
    logic wp_n;
    logic so;
    logic so_oe;
    logic so_w;

    // Undriven serial output reads high
    assign so_w = so_oe ? so : 1'b1;

    modport dev
    (
        input  cs_n,
        input  sck,
        input  si,
        input  wp_n,
        output so,
        output so_oe
    );

    modport host
    (
        output cs_n,
        output sck,
        output si,
        output wp_n,
        input  so_w
    );
endinterface : sepc_if

//--- logic/sepc_sync.sv
`timescale 1ns/100ps
module sepc_sync #(
    parameter int           W    = 4,
    parameter logic [W-1:0] INIT = '1
)
(
    // Clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // Data
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);

    logic [W-1:0] meta_r;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_r <= INIT;
            q_o    <= INIT;
        end
        else
        begin
            meta_r <= d_i;
            q_o    <= meta_r;
        end
    end

endmodule : sepc_sync

//--- logic/sepc_dev.sv
`timescale 1ns/100ps
`include "sepc_regs.svh"

module sepc_dev #(
    parameter logic [19:0] PROG_CYCLES = 20'(`SEPC_PROG_CYC),
    parameter bit          BIG         = 1'b1
)
(
    // Clock and resets
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          nv_init_n,
    // Serial link
    sepc_if.dev                link,
    // Observation
    output sepc_pkg::sepc_byte_t status_o,
    output logic               busy_o
);
    import sepc_pkg::*;

    localparam logic [10:0] AMASK = BIG ? `SEPC_MASK_BIG : `SEPC_MASK_SMALL;

    logic [3:0]   pins_s;
    logic         cs_s;
    logic         sck_s;
    logic         si_s;
    logic         wp_s;
    logic         cs_d_r;
    logic         sck_d_r;
    logic         sck_rise;
    logic         sck_fall;
    logic         cs_fall;
    logic         cs_rise;
    sepc_dphase_t phase_r;
    logic [2:0]   bit_cnt_r;
    logic [6:0]   sh_r;
    sepc_byte_t   byte_in;
    sepc_byte_t   tx_r;
    logic         out_en_r;
    logic [10:0]  addr_r;
    logic [10:0]  ladr;
    logic         is_wr_r;
    logic         pend_set_r;
    logic         pend_clr_r;
    logic         pend_arr_r;
    logic         pend_sr_r;
    sepc_byte_t   wdata_r;
    sepc_byte_t   srdata_r;
    logic         so_r;
    logic         so_oe_r;
    logic         wel_r;
    logic         busy_r;
    logic [19:0]  timer_r;
    logic         pge_r;
    logic         bgh_r;
    logic         bgl_r;
    logic         hw_lock;
    logic         arr_go;
    logic         sr_go;
    sepc_byte_t   status;
    sepc_byte_t   mem [0:2047];

    ////////////////////////////////////////////////////////////////////////
    // Pin sampling and edge detection

    sepc_sync #(
        .W    (4),
        .INIT (4'b1001)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d_i     ({link.cs_n, link.sck, link.si, link.wp_n}),
        .q_o     (pins_s)
    );

    assign {cs_s, sck_s, si_s, wp_s} = pins_s;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cs_d_r  <= 1'b1;
            sck_d_r <= 1'b0;
        end
        else
        begin
            cs_d_r  <= cs_s;
            sck_d_r <= sck_s;
        end
    end

    // Edges alone, so idle level does not matter
    assign sck_rise = sck_s & ~sck_d_r;
    assign sck_fall = ~sck_s & sck_d_r;
    assign cs_fall  = ~cs_s & cs_d_r;
    assign cs_rise  = cs_s & ~cs_d_r;
    assign byte_in  = {sh_r, si_s};

    assign status = {pge_r, 3'b000, bgh_r, bgl_r, wel_r, busy_r};
    assign ladr   = {addr_r[10:8], byte_in} & AMASK;

    ////////////////////////////////////////////////////////////////////////
    // Guard region check

    function automatic logic guarded(input logic [10:0] a,
                                     input logic [1:0]  bp);
        logic t1;
        logic t0;
        t1 = BIG ? a[10] : a[9];
        t0 = BIG ? a[9] : a[8];
        case (bp)
            2'b00:   guarded = 1'b0;
            2'b01:   guarded = t1 & t0;
            2'b10:   guarded = t1;
            default: guarded = 1'b1;
        endcase
    endfunction : guarded

    ////////////////////////////////////////////////////////////////////////
    // Instruction decode and serial shifting

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            phase_r    <= D_SKIP;
            bit_cnt_r  <= 3'd0;
            sh_r       <= 7'h00;
            tx_r       <= 8'h00;
            out_en_r   <= 1'b0;
            addr_r     <= 11'h000;
            is_wr_r    <= 1'b0;
            pend_set_r <= 1'b0;
            pend_clr_r <= 1'b0;
            pend_arr_r <= 1'b0;
            pend_sr_r  <= 1'b0;
            wdata_r    <= 8'h00;
            srdata_r   <= 8'h00;
            so_r       <= 1'b0;
        end
        else if (cs_fall)
        begin
            phase_r    <= D_OPC;
            bit_cnt_r  <= 3'd0;
            out_en_r   <= 1'b0;
            pend_set_r <= 1'b0;
            pend_clr_r <= 1'b0;
            pend_arr_r <= 1'b0;
            pend_sr_r  <= 1'b0;
        end
        else if (!cs_s && sck_rise)
        begin
            bit_cnt_r <= bit_cnt_r + 3'd1;
            sh_r      <= {sh_r[5:0], si_s};
            // Any further clocking cancels a pending latch set
            if (phase_r == D_SKIP)
                pend_set_r <= 1'b0;
            if (bit_cnt_r == 3'd7)
            begin
                case (phase_r)
                    D_OPC:
                    begin
                        if (busy_r && byte_in != `SEPC_OP_RD_SR)
                            phase_r <= D_SKIP;
                        else
                        begin
                            case (byte_in)
                                `SEPC_OP_SET_WL:
                                begin
                                    pend_set_r <= 1'b1;
                                    phase_r    <= D_SKIP;
                                end
                                `SEPC_OP_CLR_WL:
                                begin
                                    pend_clr_r <= 1'b1;
                                    phase_r    <= D_SKIP;
                                end
                                `SEPC_OP_RD_SR:
                                begin
                                    tx_r     <= status;
                                    out_en_r <= 1'b1;
                                    phase_r  <= D_SROUT;
                                end
                                `SEPC_OP_WR_SR:
                                    phase_r <= D_SRIN;
                                `SEPC_OP_RD_MEM:
                                begin
                                    is_wr_r <= 1'b0;
                                    phase_r <= D_ADH;
                                end
                                `SEPC_OP_WR_MEM:
                                begin
                                    is_wr_r <= 1'b1;
                                    phase_r <= D_ADH;
                                end
                                default:
                                    phase_r <= D_SKIP;
                            endcase
                        end
                    end
                    D_ADH:
                    begin
                        addr_r[10:8] <= byte_in[2:0];
                        phase_r      <= D_ADL;
                    end
                    D_ADL:
                    begin
                        if (is_wr_r)
                        begin
                            addr_r  <= ladr;
                            phase_r <= D_WIN;
                        end
                        else
                        begin
                            tx_r     <= mem[ladr];
                            addr_r   <= 11'(ladr + 11'd1) & AMASK;
                            out_en_r <= 1'b1;
                            phase_r  <= D_RDOUT;
                        end
                    end
                    D_RDOUT:
                    begin
                        tx_r   <= mem[addr_r];
                        addr_r <= 11'(addr_r + 11'd1) & AMASK;
                    end
                    D_SROUT:
                        tx_r <= status;
                    D_WIN:
                    begin
                        wdata_r    <= byte_in;
                        pend_arr_r <= 1'b1;
                        phase_r    <= D_SKIP;
                    end
                    D_SRIN:
                    begin
                        srdata_r  <= byte_in;
                        pend_sr_r <= 1'b1;
                        phase_r   <= D_SKIP;
                    end
                    default:
                        phase_r <= D_SKIP;
                endcase
            end
        end
        else if (!cs_s && sck_fall && out_en_r)
        begin
            so_r <= tx_r[7];
            tx_r <= {tx_r[6:0], 1'b0};
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            so_oe_r <= 1'b0;
        else
            so_oe_r <= ~cs_s;
    end

    ////////////////////////////////////////////////////////////////////////
    // Write gating and programming

    assign hw_lock = pge_r & ~wp_s;
    assign arr_go  = cs_rise & ~busy_r & pend_arr_r & wel_r
                   & ~guarded(addr_r, {bgh_r, bgl_r});
    assign sr_go   = cs_rise & ~busy_r & pend_sr_r & wel_r
                   & ~hw_lock;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wel_r   <= 1'b0;
            busy_r  <= 1'b0;
            timer_r <= 20'd0;
        end
        else if (busy_r)
        begin
            if (timer_r <= 20'd1)
            begin
                busy_r <= 1'b0;
                wel_r  <= 1'b0;
            end
            else
                timer_r <= timer_r - 20'd1;
        end
        else if (arr_go || sr_go)
        begin
            busy_r  <= 1'b1;
            timer_r <= PROG_CYCLES;
        end
        else if (cs_rise && pend_set_r)
            wel_r <= 1'b1;
        else if (cs_rise && pend_clr_r)
            wel_r <= 1'b0;
    end

    // Guard bits survive presetn; only nv_init_n or a status write clears them
    always_ff @(posedge pclk or negedge nv_init_n)
    begin
        if (!nv_init_n)
        begin
            pge_r <= 1'b0;
            bgh_r <= 1'b0;
            bgl_r <= 1'b0;
        end
        else if (sr_go)
        begin
            pge_r <= srdata_r[`SEPC_SR_PGE];
            bgh_r <= srdata_r[`SEPC_SR_BGH];
            bgl_r <= srdata_r[`SEPC_SR_BGL];
        end
    end

    always_ff @(posedge pclk)
    begin
        if (arr_go)
            mem[addr_r] <= wdata_r;
    end

    assign link.so    = so_r;
    assign link.so_oe = so_oe_r;
    assign status_o   = status;
    assign busy_o     = busy_r;

endmodule : sepc_dev

//--- logic/sepc_host.sv
`timescale 1ns/100ps
`include "sepc_regs.svh"

module sepc_host
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Serial link
    sepc_if.host             link
);
    import sepc_pkg::*;

    localparam logic [3:0] HALF = 4'(`SEPC_SCK_HALF_CYC);

    sepc_hstate_t st_r;
    logic [3:0]   div_r;
    logic         tick;
    logic [31:0]  sh_r;
    logic [5:0]   bits_r;
    sepc_byte_t   rx_r;
    sepc_byte_t   op_r;
    logic         has_addr_r;
    logic         has_data_r;
    logic [15:0]  addr_r;
    sepc_byte_t   txd_r;
    sepc_byte_t   rxd_r;
    logic         wp_r;
    logic         cs_n_r;
    logic         sck_r;
    logic         si_r;
    logic         so_s;
    logic         wr_go;
    logic         start;
    logic         busy;
    logic         mapped;

    ////////////////////////////////////////////////////////////////////////
    // APB slave, no wait states

    assign wr_go  = psel & penable & pready & pwrite;
    assign busy   = st_r != H_IDLE;
    assign start  = wr_go & (paddr == `SEPC_CMD_OFS) & ~busy;
    assign mapped = paddr == `SEPC_CMD_OFS || paddr == `SEPC_ADDR_OFS
                 || paddr == `SEPC_TXD_OFS || paddr == `SEPC_RXD_OFS
                 || paddr == `SEPC_CTRL_OFS || paddr == `SEPC_STAT_OFS;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= psel & ~penable & ~pready;
            pslverr <= psel & ~penable & ~pready & ~mapped;
            case (paddr)
                `SEPC_CMD_OFS:  prdata <= {22'h0, has_data_r, has_addr_r, op_r};
                `SEPC_ADDR_OFS: prdata <= {16'h0, addr_r};
                `SEPC_TXD_OFS:  prdata <= {24'h0, txd_r};
                `SEPC_RXD_OFS:  prdata <= {24'h0, rxd_r};
                `SEPC_CTRL_OFS: prdata <= {31'h0, wp_r};
                `SEPC_STAT_OFS: prdata <= {31'h0, busy};
                default:        prdata <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            op_r       <= 8'h00;
            has_addr_r <= 1'b0;
            has_data_r <= 1'b0;
            addr_r     <= 16'h0000;
            txd_r      <= 8'h00;
            wp_r       <= `SEPC_CTRL_RST;
        end
        else if (wr_go)
        begin
            if (start)
            begin
                op_r       <= pwdata[7:0];
                has_addr_r <= pwdata[`SEPC_CMD_HAS_ADDR];
                has_data_r <= pwdata[`SEPC_CMD_HAS_DATA];
            end
            if (paddr == `SEPC_ADDR_OFS)
                addr_r <= pwdata[15:0];
            if (paddr == `SEPC_TXD_OFS)
                txd_r <= pwdata[7:0];
            if (paddr == `SEPC_CTRL_OFS)
                wp_r <= pwdata[`SEPC_CTRL_WP];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Serial engine, mode zero-zero

    sepc_sync #(
        .W    (1),
        .INIT (1'b1)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d_i     (link.so_w),
        .q_o     (so_s)
    );

    assign tick = div_r == HALF - 4'd1;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_r   <= H_IDLE;
            div_r  <= 4'd0;
            sh_r   <= 32'h0000_0000;
            bits_r <= 6'd0;
            rx_r   <= 8'h00;
            rxd_r  <= 8'h00;
            cs_n_r <= 1'b1;
            sck_r  <= 1'b0;
            si_r   <= 1'b0;
        end
        else
        begin
            div_r <= (st_r == H_IDLE || tick) ? 4'd0 : div_r + 4'd1;
            case (st_r)
                H_IDLE:
                begin
                    if (start)
                    begin
                        if (pwdata[`SEPC_CMD_HAS_ADDR])
                            sh_r <= {pwdata[7:0], addr_r, txd_r};
                        else
                            sh_r <= {pwdata[7:0], txd_r, 16'h0000};
                        si_r   <= pwdata[7];
                        bits_r <= 6'd8
                                + (pwdata[`SEPC_CMD_HAS_ADDR] ? 6'd16 : 6'd0)
                                + (pwdata[`SEPC_CMD_HAS_DATA] ? 6'd8 : 6'd0);
                        cs_n_r <= 1'b0;
                        st_r   <= H_LEAD;
                    end
                end
                H_LEAD:
                    if (tick)
                        st_r <= H_SHIFT;
                H_SHIFT:
                begin
                    if (tick && !sck_r)
                    begin
                        sck_r <= 1'b1;
                        rx_r  <= {rx_r[6:0], so_s};
                    end
                    else if (tick)
                    begin
                        sck_r  <= 1'b0;
                        bits_r <= bits_r - 6'd1;
                        if (bits_r == 6'd1)
                        begin
                            rxd_r <= rx_r;
                            st_r  <= H_TRAIL;
                        end
                        else
                        begin
                            sh_r <= {sh_r[30:0], 1'b0};
                            si_r <= sh_r[30];
                        end
                    end
                end
                H_TRAIL:
                    if (tick)
                    begin
                        cs_n_r <= 1'b1;
                        st_r   <= H_GAP;
                    end
                H_GAP:
                    if (tick)
                        st_r <= H_IDLE;
                default:
                    st_r <= H_IDLE;
            endcase
        end
    end

    assign link.cs_n = cs_n_r;
    assign link.sck  = sck_r;
    assign link.si   = si_r;
    assign link.wp_n = wp_r;

endmodule : sepc_host

//--- verif/sepc_monitor.sv
`timescale 1ns/100ps
module sepc_monitor
(
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Serial link
    input  wire logic cs_n,
    input  wire logic sck,
    input  wire logic si,
    input  wire logic so,
    input  wire logic so_oe
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    ////////////////////////////////////////////////////////////
    sck_idle_low_a: assert property (cs_n |-> !sck)
        else $error("clock runs while deselected");
    lead_quiet_a: assert property ($fell(cs_n) |-> !sck [*8])
        else $error("clock too soon after select");
    gap_high_a: assert property ($rose(cs_n) |-> cs_n [*8])
        else $error("select gap too short");
    high_half_a: assert property ($rose(sck) |-> sck [*8])
        else $error("clock high phase too short");
    si_steady_a: assert property ($rose(sck) |-> $stable(si))
        else $error("data in moved at rising clock");
    so_on_fall_a: assert property
        (!cs_n && so_oe && $changed(so) |-> !sck)
        else $error("data out moved while clock high");
    oe_on_a: assert property ($fell(cs_n) |-> ##[2:6] so_oe)
        else $error("output not driven in frame");
    oe_off_a: assert property ($rose(cs_n) |-> ##[2:6] !so_oe)
        else $error("output still driven when idle");
endmodule : sepc_monitor

//--- verif/testbench.sv
`timescale 1ns/100ps
module testbench;
    import sepc_pkg::*;
`define CHK(a, e) chk((a) === (e))
    logic        pclk = 1'b0, presetn = 1'b0, nv_init_n = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic        pready, pslverr, err, busy_o;
    sepc_byte_t  status_o;
    int          mismatches = 0, n_compared = 0;

    sepc_if lnk();
    sepc_dev #(.PROG_CYCLES(20'd2000), .BIG(1'b1)) i_sepc_dev (.pclk(pclk),
        .presetn(presetn), .nv_init_n(nv_init_n), .link(lnk),
        .status_o(status_o), .busy_o(busy_o));
    sepc_host i_sepc_host (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(lnk));
    sepc_monitor i_sepc_monitor (.pclk(pclk), .presetn(presetn),
        .cs_n(lnk.cs_n), .sck(lnk.sck), .si(lnk.si), .so(lnk.so),
        .so_oe(lnk.so_oe));

    always #5 pclk = ~pclk;

    ////////////////////////////////////////////////////////////
    task automatic chk(input bit ok);
        n_compared++;
        if (!ok)
        begin
            mismatches++;
            $display("unexpected at %0t: value mismatch", $time);
        end
    endtask : chk

    task automatic wrap_up;
        $display("compared %0d, mismatched %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : wrap_up

    task automatic hang;
        mismatches++;
        $display("unexpected at %0t: wait ran out", $time);
        wrap_up();
    endtask : hang

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        @(posedge pclk);
        while (pready !== 1'b1)
        begin
            if (++n > 50) hang();
            @(posedge pclk);
        end
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Start a frame and wait for the controller to go idle
    task automatic frame(input logic [15:0] c, input logic [15:0] a,
                         input logic [7:0] d);
        int n;
        apb(1'b1, 8'h04, {16'h0, a});
        apb(1'b1, 8'h08, {24'h0, d});
        apb(1'b1, 8'h00, {16'h0, c});
        n = 0;
        do
        begin
            if (++n > 400) hang();
            apb(1'b0, 8'h14, 32'h0);
        end
        while (q[0] !== 1'b0);
    endtask : frame

    task automatic idle;
        int n;
        n = 0;
        while (busy_o !== 1'b0)
        begin
            if (++n > 3000) hang();
            @(posedge pclk);
        end
    endtask : idle

    task automatic op(input logic [15:0] c, input logic [15:0] a,
                      input logic [7:0] d);
        frame(c, a, d);
        idle();
    endtask : op

    task automatic rd(input logic [15:0] a);
        op(16'h303, a, 8'h00);
        apb(1'b0, 8'h0c, 32'h0);
    endtask : rd

    ////////////////////////////////////////////////////////////
    task automatic t_reset;
        `CHK(status_o, 8'h00);
        apb(1'b0, 8'h20, 32'h0);
        `CHK(err, 1'b1);
        apb(1'b0, 8'h10, 32'h0);
        `CHK(q, 32'h1);
        op(16'h205, 16'h0, 8'h00);
        apb(1'b0, 8'h0c, 32'h0);
        `CHK(q, 32'h0);
        $display("reset test done");
    endtask : t_reset

    task automatic t_latch;
        op(16'h006, 16'h0, 8'h00);
        `CHK(status_o, 8'h02);
        op(16'h084, 16'h0, 8'h00);
        `CHK(status_o, 8'h02);
        op(16'h004, 16'h0, 8'h00);
        `CHK(status_o, 8'h00);
        op(16'h206, 16'h0, 8'h00);
        `CHK(status_o, 8'h00);
        op(16'h201, 16'h0, 8'h8c);
        `CHK(status_o, 8'h00);
        $display("latch test done");
    endtask : t_latch

    task automatic t_array;
        op(16'h006, 16'h0, 8'h00);
        op(16'h302, 16'h0600, 8'h11);
        `CHK(status_o, 8'h00);
        rd(16'h0600);
        `CHK(q, 32'h11);
        op(16'h006, 16'h0, 8'h00);
        op(16'h302, 16'hf5ff, 8'h33);
        rd(16'h05ff);
        `CHK(q, 32'h33);
        op(16'h302, 16'h05ff, 8'h44);
        rd(16'h05ff);
        `CHK(q, 32'h33);
        $display("array test done");
    endtask : t_array

    task automatic t_status;
        op(16'h006, 16'h0, 8'h00);
        frame(16'h201, 16'h0, 8'hff);
        `CHK(busy_o, 1'b1);
        frame(16'h205, 16'h0, 8'h00);
        apb(1'b0, 8'h0c, 32'h0);
        `CHK(q, 32'h8f);
        idle();
        `CHK(status_o, 8'h8c);
        apb(1'b1, 8'h10, 32'h0);
        op(16'h006, 16'h0, 8'h00);
        op(16'h201, 16'h0, 8'h00);
        `CHK(status_o[7:2], 6'h23);
        apb(1'b1, 8'h10, 32'h1);
        op(16'h006, 16'h0, 8'h00);
        op(16'h201, 16'h0, 8'h04);
        `CHK(status_o, 8'h04);
        $display("status test done");
    endtask : t_status

    task automatic t_guard;
        op(16'h006, 16'h0, 8'h00);
        op(16'h302, 16'h0600, 8'h22);
        rd(16'h0600);
        `CHK(q, 32'h11);
        op(16'h006, 16'h0, 8'h00);
        op(16'h302, 16'h05ff, 8'h55);
        rd(16'h05ff);
        `CHK(q, 32'h55);
        op(16'h006, 16'h0, 8'h00);
        `CHK(status_o, 8'h06);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        `CHK(status_o, 8'h04);
        $display("guard test done");
    endtask : t_guard

    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        nv_init_n <= 1'b1;
        repeat (3) @(posedge pclk);
        t_reset();
        t_latch();
        t_array();
        t_status();
        t_guard();
        wrap_up();
    end
endmodule : testbench
